// ==== src/supply_thermal_fault_status_regs.v ====
// How it works
// - bit7 low: read addressed byte, unchanged
// - bit7 high: clear whole addressed byte
// - flags never self-clear; host clears them
// - supply byte at 0x41, resets to 0x80
// - soft reset clears power-on flag
// - bit4: secondary rail short or hot
// - bit3: secondary rail fail event
// - bit2: main rail short after switch-on
// - bit1: main rail fail event
// - bit0: main rail undervoltage reset crossed
// - sleep with main rail off suppresses bits2:0
// - thermal byte at 0x42, bits7:5 zero
// - bits4:2 count hard thermal restarts
// - count seven holds; next event restarts at one
// - self-reset count only below seven per minute
// - shutdown and prewarning flags stay sticky
// - bits7:6 hold prior state code
// - bits5:2 watchdog failure count, max 15
// - bad-command flag set on invalid command
// - fail-output flag set on pin activation
// - good watchdog trigger clears failure count
// - bad-command flag cleared only by host clear, soft reset or reset
`timescale 1ns/1ps

module supply_thermal_fault_status_regs (
   input  wire       clock,
   input  wire       rst_b,
   input  wire       soft_reset,
   input  wire       frame_valid,
   input  wire [7:0] frame_cmd,
   input  wire       sleep_main_off,
   input  wire       battery_undervoltage,
   input  wire       battery_overvoltage,
   input  wire       secondary_rail_short_or_hot,
   input  wire       secondary_rail_fail,
   input  wire       main_rail_short,
   input  wire       main_rail_fail,
   input  wire       main_rail_undervoltage,
   input  wire       hard_thermal_event,
   input  wire       hard_thermal_window_reset,
   input  wire       thermal_shutdown_flag,
   input  wire       thermal_prewarning,
   input  wire       prior_state_set,
   input  wire [1:0] prior_state_code,
   input  wire       watchdog_failure,
   input  wire       watchdog_trigger_ok,
   input  wire       bad_command,
   input  wire       fail_output_pin,
   output reg  [7:0] read_data_q,
   output reg        read_valid_q,
   output reg        addr_hit_q
);

`include "status_regs.vh"

// =====================================================
// address decode
   function [2:0] decode;
      input [6:0] addr;
      begin
         if (addr == `ADDR_SUPPLY) begin
            decode = 3'b001;
         end else if (addr == `ADDR_THERMAL) begin
            decode = 3'b010;
         end else if (addr == `ADDR_DEVINFO) begin
            decode = 3'b100;
         end else begin
            decode = 3'b000;
         end
      end
   endfunction

   wire [2:0] sel     = decode(frame_cmd[6:0]);
   wire       is_clr  = frame_valid & frame_cmd[`BIT_CLEAR];
   wire       clr_sup = is_clr & sel[0];
   wire       clr_thm = is_clr & sel[1];
   wire       clr_dev = is_clr & sel[2];

   wire [7:0] supply_q;
   wire [7:0] thermal_q;
   wire [7:0] devinfo_q;
   reg  [7:0] sup_d;
   reg  [7:0] thm_d;
   reg  [7:0] dev_d;
   reg  [1:0] rd_idx;
   reg  [2:0] ht_cnt;
   reg  [3:0] wd_cnt;

// =====================================================
// next values: clear first, then events set on top
   always @* begin
      // a clear yields zero, events OR back in so set wins
      sup_d = clr_sup ? `BYTE_ZERO : supply_q;
      sup_d[`BIT_BATT_UV] = sup_d[`BIT_BATT_UV] | battery_undervoltage;
      sup_d[`BIT_BATT_OV] = sup_d[`BIT_BATT_OV] | battery_overvoltage;
      sup_d[`BIT_SEC_SC_OT] = sup_d[`BIT_SEC_SC_OT]
                            | secondary_rail_short_or_hot;
      sup_d[`BIT_SEC_FAIL] = sup_d[`BIT_SEC_FAIL]
                           | secondary_rail_fail;
      if (!sleep_main_off) begin
         sup_d[`BIT_MAIN_SC] = sup_d[`BIT_MAIN_SC]
                             | main_rail_short;
         sup_d[`BIT_MAIN_FAIL] = sup_d[`BIT_MAIN_FAIL]
                               | main_rail_fail;
         sup_d[`BIT_MAIN_UV] = sup_d[`BIT_MAIN_UV]
                             | main_rail_undervoltage;
      end

      // hard thermal count
      ht_cnt = clr_thm ? `HT_COUNT_ZERO : thermal_q[4:2];
      if (hard_thermal_event) begin
         // count on from the cleared value so a clear never eats an event
         if (ht_cnt == `HT_COUNT_MAX) begin
            ht_cnt = `HT_COUNT_ONE;
         end else begin
            ht_cnt = ht_cnt + `HT_COUNT_ONE;
         end
      end else if (hard_thermal_window_reset
                   && thermal_q[4:2] != `HT_COUNT_MAX) begin
         // a saturated count is kept to show fail-safe was entered
         ht_cnt = `HT_COUNT_ZERO;
      end
      thm_d = `BYTE_ZERO;
      thm_d[4:2] = ht_cnt;
      thm_d[`BIT_TSD_FLAG] = (thermal_q[`BIT_TSD_FLAG] & ~clr_thm)
                           | thermal_shutdown_flag;
      thm_d[`BIT_PREWARN] = (thermal_q[`BIT_PREWARN] & ~clr_thm)
                          | thermal_prewarning;

      // device info
      dev_d = clr_dev ? `BYTE_ZERO : devinfo_q;
      if (prior_state_set) begin
         dev_d[7:6] = prior_state_code;
      end
      wd_cnt = dev_d[5:2];
      if (watchdog_trigger_ok) begin
         wd_cnt = `WD_COUNT_ZERO;
      end
      if (watchdog_failure && wd_cnt != `WD_COUNT_MAX) begin
         // counting from the pre-clear value would lose the event
         wd_cnt = wd_cnt + `WD_COUNT_ONE;
      end
      dev_d[5:2] = wd_cnt;
      dev_d[`BIT_BAD_CMD] = dev_d[`BIT_BAD_CMD] | bad_command;
      dev_d[`BIT_FAIL_OUT] = dev_d[`BIT_FAIL_OUT] | fail_output_pin;
   end

   always @* begin
      if (sel[0]) begin
         rd_idx = 2'd0;
      end else if (sel[1]) begin
         rd_idx = 2'd1;
      end else if (sel[2]) begin
         rd_idx = 2'd2;
      end else begin
         rd_idx = 2'd3;
      end
   end

// =====================================================
// storage: written every cycle with its next value
   status_byte_store u_store (
      .clock      (clock),
      .rst_b      (rst_b),
      .soft_reset (soft_reset),
      .wr_en      (1'b1),
      .wr_index   (2'd0),
      .wr_data    (sup_d),
      .rd_index   (rd_idx),
      .rd_data_q  (),
      .supply_q   (supply_q),
      .thermal_q  (),
      .devinfo_q  ()
   );

   reg [7:0] thm_q;
   reg [7:0] dev_q;
   assign thermal_q = thm_q;
   assign devinfo_q = dev_q;

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         thm_q <= `THERMAL_RESET;
         dev_q <= `DEVINFO_RESET;
      end else if (soft_reset) begin
         thm_q <= `THERMAL_RESET;
         dev_q <= `DEVINFO_RESET;
      end else begin
         thm_q <= thm_d;
         dev_q <= dev_d;
      end
   end

// =====================================================
// read answer: pre-clear snapshot, one cycle after frame
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         read_data_q  <= `BYTE_ZERO;
         read_valid_q <= 1'b0;
         addr_hit_q   <= 1'b0;
      end else begin
         // bytes are taken before this edge's update, so a clear
         // still answers with the old contents
         read_data_q  <= frame_valid ? (sel[0] ? supply_q : (sel[1]
                         ? (thermal_q & `THERM_MASK)
                         : (sel[2] ? devinfo_q : `BYTE_ZERO)))
                         : read_data_q;
         read_valid_q <= frame_valid;
         addr_hit_q   <= frame_valid & (|sel);
      end
   end

endmodule

// ==== src/status_regs.vh ====
`ifndef STATUS_REGS_REGS_VH
`define STATUS_REGS_REGS_VH

// =====================================================
// register addresses (7-bit)
`define ADDR_SUPPLY   7'h41
`define ADDR_THERMAL  7'h42
`define ADDR_DEVINFO  7'h43

// =====================================================
// reset values
`define SUPPLY_RESET  8'h80
`define THERMAL_RESET 8'h00
`define DEVINFO_RESET 8'h00

// =====================================================
// field positions
`define BIT_CLEAR      7
`define BIT_POWER_ON   7
`define BIT_BATT_UV    6
`define BIT_BATT_OV    5
`define BIT_SEC_SC_OT  4
`define BIT_SEC_FAIL   3
`define BIT_MAIN_SC    2
`define BIT_MAIN_FAIL  1
`define BIT_MAIN_UV    0
`define BIT_TSD_FLAG   1
`define BIT_PREWARN    0
`define BIT_BAD_CMD    1
`define BIT_FAIL_OUT   0

// =====================================================
// field values
`define THERM_MASK     8'h1F
`define HT_COUNT_MAX   3'h7
`define HT_COUNT_ONE   3'h1
`define HT_COUNT_ZERO  3'h0
`define WD_COUNT_MAX   4'hF
`define WD_COUNT_ZERO  4'h0
`define WD_COUNT_ONE   4'h1
`define PRIOR_CLEARED  2'h0
`define PRIOR_FAILURE  2'h1
`define PRIOR_SLEEP    2'h2
`define BYTE_ZERO      8'h00
`define REG_INDEX_W    2

`endif

// ==== src/status_byte_store.v ====
`timescale 1ns/1ps

// =====================================================
// three status bytes, registered read port
module status_byte_store (
   input  wire       clock,
   input  wire       rst_b,
   input  wire       soft_reset,
   input  wire       wr_en,
   input  wire [1:0] wr_index,
   input  wire [7:0] wr_data,
   input  wire [1:0] rd_index,
   output reg  [7:0] rd_data_q,
   output reg  [7:0] supply_q,
   output reg  [7:0] thermal_q,
   output reg  [7:0] devinfo_q
);

`include "status_regs.vh"

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         supply_q  <= `SUPPLY_RESET;
         thermal_q <= `THERMAL_RESET;
         devinfo_q <= `DEVINFO_RESET;
      end else if (soft_reset) begin
         // soft reset clears the power-on flag too
         supply_q  <= `BYTE_ZERO;
         thermal_q <= `THERMAL_RESET;
         devinfo_q <= `DEVINFO_RESET;
      end else if (wr_en) begin
         if (wr_index == 2'd0) begin
            supply_q <= wr_data;
         end else if (wr_index == 2'd1) begin
            thermal_q <= wr_data & `THERM_MASK;
         end else if (wr_index == 2'd2) begin
            devinfo_q <= wr_data;
         end
      end
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= `BYTE_ZERO;
      end else if (rd_index == 2'd0) begin
         rd_data_q <= supply_q;
      end else if (rd_index == 2'd1) begin
         rd_data_q <= thermal_q & `THERM_MASK;
      end else if (rd_index == 2'd2) begin
         rd_data_q <= devinfo_q;
      end else begin
         rd_data_q <= `BYTE_ZERO;
      end
   end

endmodule

// ==== test/status_regs_asserts.sv ====
`timescale 1ns/1ps
`include "status_regs.vh"

// ====================
// frame answer checks
module status_regs_checker (
   input wire       clock,
   input wire       rst_b,
   input wire       soft_reset,
   input wire       frame_valid,
   input wire [7:0] frame_cmd,
   input wire [7:0] read_data_q,
   input wire       read_valid_q,
   input wire       addr_hit_q
);
   wire mapped = frame_cmd[6:0] >= `ADDR_SUPPLY
                 && frame_cmd[6:0] <= `ADDR_DEVINFO;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence supply_read;
      frame_valid && frame_cmd == {1'b0, `ADDR_SUPPLY} && !soft_reset;
   endsequence

   answer_next_a: assert property (frame_valid |=> read_valid_q)
      else $error("no answer after frame");
   quiet_idle_a: assert property (!frame_valid |=> !read_valid_q)
      else $error("answer without frame");
   data_holds_a: assert property (!frame_valid |=> $stable(read_data_q))
      else $error("read byte moved without frame");
   hit_in_answer_a: assert property (addr_hit_q |-> read_valid_q)
      else $error("hit outside answer");
   unmapped_refused_a: assert property (
      frame_valid && !mapped |=> !addr_hit_q && read_data_q == 8'h00)
      else $error("unmapped address answered");
   mapped_hit_a: assert property (frame_valid && mapped |=> addr_hit_q)
      else $error("mapped address missed");
   thermal_reserved_a: assert property (
      frame_valid && frame_cmd[6:0] == `ADDR_THERMAL
      |=> read_data_q[7:5] == 3'h0)
      else $error("thermal reserved bits set");
   supply_sticky_a: assert property (
      supply_read ##1 supply_read
      |=> ($past(read_data_q) & ~read_data_q) == 8'h00)
      else $error("supply flag dropped without clear");
endmodule

bind supply_thermal_fault_status_regs status_regs_checker
   status_regs_checker_inst (
   .clock(clock), .rst_b(rst_b), .soft_reset(soft_reset),
   .frame_valid(frame_valid), .frame_cmd(frame_cmd),
   .read_data_q(read_data_q), .read_valid_q(read_valid_q),
   .addr_hit_q(addr_hit_q)
);

// ==== test/host_frame_model.sv ====
`timescale 1ns/1ps

// ====================
// serial master, one decoded frame per call
module host_frame_model (
   output logic       frame_valid,
   output logic [7:0] frame_cmd
);
   initial begin
      frame_valid = 1'b0;
      frame_cmd   = 8'h00;
   end

   // idle lines show the inverse, so a stale command returns on every second idle call
   task put(input logic v, input logic c, input logic [6:0] a);
      frame_valid = v;
      frame_cmd   = v ? {c, a} : ~frame_cmd;
   endtask
endmodule

// ==== test/supply_thermal_fault_status_regs_bench.sv ====
`timescale 1ns/1ps
`include "status_regs.vh"
`define CHK(n, x, g) checks++; if ((g) !== (x)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", n, x, g); end

module supply_thermal_fault_status_regs_bench;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [19:0] e = 20'h0;
   logic [19:0] x;
   logic [31:0] r;
   wire         fv;
   wire  [7:0]  fc;
   wire  [7:0]  rd;
   wire         rv;
   wire         ah;
   logic [7:0]  sup;
   logic [7:0]  thm;
   logic [7:0]  dev;
   logic [8:0]  ex;
   logic [8:0]  expq[$];
   int          n_fail = 0;
   int          checks = 0;
   int          seed = 82;
   int          i;

   always #50 clock = ~clock;

   host_frame_model host_frame_model_inst (
      .frame_valid (fv),
      .frame_cmd   (fc)
   );

   supply_thermal_fault_status_regs supply_thermal_fault_status_regs_inst (
      .clock(clock), .rst_b(rst_b), .soft_reset(e[0]),
      .frame_valid(fv), .frame_cmd(fc), .sleep_main_off(e[1]),
      .battery_undervoltage(e[5]), .battery_overvoltage(e[4]),
      .secondary_rail_short_or_hot(e[3]), .secondary_rail_fail(e[2]),
      .main_rail_short(e[8]), .main_rail_fail(e[7]),
      .main_rail_undervoltage(e[6]), .hard_thermal_event(e[9]),
      .hard_thermal_window_reset(e[10]), .thermal_shutdown_flag(e[12]),
      .thermal_prewarning(e[11]), .prior_state_set(e[13]),
      .prior_state_code(e[19:18]), .watchdog_failure(e[14]),
      .watchdog_trigger_ok(e[15]), .bad_command(e[17]),
      .fail_output_pin(e[16]), .read_data_q(rd), .read_valid_q(rv),
      .addr_hit_q(ah)
   );

   // ====================
   // one cycle of stimulus plus the reference state update
   task step(input [19:0] s, input v, input c, input [6:0] a);
      logic [2:0] m;
      logic [2:0] k;
      logic [2:0] t;
      logic [3:0] w;
      #1;
      e = s;
      host_frame_model_inst.put(v, c, a);
      m = {a == `ADDR_DEVINFO, a == `ADDR_THERMAL, a == `ADDR_SUPPLY};
      k = {3{v & c}} & m;
      if (v)
         expq.push_back({|m, {8{m[0]}} & sup | {8{m[1]}} & thm
            | {8{m[2]}} & dev});
      t = k[1] ? `HT_COUNT_ZERO : thm[4:2];
      if (s[9])
         t = t == `HT_COUNT_MAX ? `HT_COUNT_ONE : t + 3'h1;
      if (s[10] && t != `HT_COUNT_MAX)
         t = `HT_COUNT_ZERO;
      w = k[2] || s[15] ? `WD_COUNT_ZERO : dev[5:2];
      if (s[14] && w != `WD_COUNT_MAX)
         w = w + 4'h1;
      // set wins over a clear in the same cycle
      sup = (k[0] ? 8'h00 : sup) | {1'b0, s[5:2], s[8:6] & ~{3{s[1]}}};
      thm = {3'h0, t, (k[1] ? 2'h0 : thm[1:0]) | s[12:11]};
      dev = {s[13] ? s[19:18] : k[2] ? 2'h0 : dev[7:6], w,
         (k[2] ? 2'h0 : dev[1:0]) | s[17:16]};
      if (s[0])
         {sup, thm, dev} = 24'h0;
      @(posedge clock);
   endtask

   task rst;
      #1;
      rst_b = 1'b0;
      e = 20'h0;
      host_frame_model_inst.put(1'b0, 1'b0, 7'h0);
      expq = {};
      repeat (3) @(posedge clock);
      #1;
      rst_b = 1'b1;
      sup = `SUPPLY_RESET;
      thm = `THERMAL_RESET;
      dev = `DEVINFO_RESET;
      @(posedge clock);
   endtask

   task give_verdict;
      `CHK("pending answers", 32'h0, expq.size())
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clock) begin
      if (rv === 1'b1) begin
         ex = expq.size() > 0 ? expq.pop_front() : 9'h1FF;
         `CHK("read byte", ex[7:0], rd)
         `CHK("address hit", ex[8], ah)
      end
   end

   initial begin
      rst;
      for (i = 0; i < 5; i++)
         step(20'h0, 1'b1, 1'b0, 7'h40 + i[6:0]);
      step(20'h0, 1'b1, 1'b1, `ADDR_SUPPLY);
      step(20'h01000, 1'b1, 1'b1, `ADDR_THERMAL);
      step(20'h0, 1'b1, 1'b0, `ADDR_SUPPLY);
      step(20'h0, 1'b1, 1'b0, `ADDR_THERMAL);
      for (i = 0; i < 8; i++)
         step(i < 7 ? 20'h00200 : 20'h00400, 1'b0, 1'b0, 7'h0);
      step(20'h00200, 1'b1, 1'b0, `ADDR_THERMAL);
      step(20'h00400, 1'b1, 1'b0, `ADDR_THERMAL);
      for (i = 0; i < 16; i++)
         step(20'h04000, 1'b0, 1'b0, 7'h0);
      step(20'h08000, 1'b1, 1'b0, `ADDR_DEVINFO);
      step(20'h001C2, 1'b1, 1'b0, `ADDR_DEVINFO);
      step(20'h001C0, 1'b1, 1'b0, `ADDR_SUPPLY);
      step(20'h00001, 1'b1, 1'b0, `ADDR_SUPPLY);
      step(20'h0, 1'b1, 1'b0, `ADDR_SUPPLY);
      // let the last answer be compared before reset drops it
      step(20'h0, 1'b0, 1'b0, 7'h0);
      step(20'h0, 1'b0, 1'b0, 7'h0);
      rst;
      for (i = 0; i < 600; i++) begin
         x = $random(seed) & $random(seed) & $random(seed);
         r = $random(seed);
         x[10] = x[10] & ~x[9];
         x[19:18] = {x[18], ~x[18]};
         x[0] = &x[2:0];
         if (x[0])
            x = 20'h1;
         step(x, r[4], r[5], 7'h40 + {3'h0, r[3:0] % 4'h5});
      end
      step(20'h0, 1'b0, 1'b0, 7'h0);
      step(20'h0, 1'b0, 1'b0, 7'h0);
      give_verdict;
   end

   initial begin
      #200000;
      n_fail++;
      give_verdict;
   end
endmodule
